// ===== design/rtc_bus_controller.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_bus_controller
    import rtc_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Serial link
    rtc_link_if.controller bus,
    // Command
    input wire logic cmd_valid,
    input wire cmd_kind_t cmd_kind,
    input wire logic [7:0] cmd_loc,
    input wire logic [7:0] cmd_len,
    output logic cmd_ready,
    // Write data
    input wire logic [7:0] wdata,
    output logic wdata_take,
    // Read data and status
    output logic [7:0] rdata,
    output logic rdata_valid,
    output logic done,
    output logic nack_err
);

    ctl_regs_t q;
    ctl_regs_t d;
    logic tick;

    assign tick = (q.div == `QDIV_W'(`SCL_QUARTER_CYC - 1));

    always_comb begin
        d = q;
        d.wdata_take = 1'b0;
        d.rdata_valid = 1'b0;
        d.done = 1'b0;
        d.sda_s1 = bus.sda;
        d.sda_s2 = q.sda_s1;
        d.sda_o = 1'b0;
        d.div = tick ? '0 : q.div + `QDIV_W'(1);
        if (q.state == cs_idle) begin
            d.div = '0;
            d.qph = 2'h0;
            if (cmd_valid) begin
                d.ready = 1'b0;
                d.nack_err = 1'b0;
                d.kind = cmd_kind;
                d.loc = cmd_loc;
                d.left = cmd_len;
                // RULE_05: plain read starts with read address
                d.stage = (cmd_kind == ck_read) ? sg_addr_r : sg_addr_w;
                d.state = cs_start;
            end
        end else if (tick) begin
            d.qph = q.qph + 2'h1;
            case (q.state)
                cs_start: begin
                    case (q.qph)
                        // Clock low first so a repeated START sees a released line
                        2'h0: begin
                            d.scl = 1'b0;
                            d.sda_oe_n = 1'b1;
                        end
                        2'h1: d.scl = 1'b1;
                        2'h2: d.sda_oe_n = 1'b0;
                        default: begin
                            d.scl = 1'b0;
                            d.bitn = 4'h0;
                            d.sh = (q.stage == sg_addr_r) ? (`TARGET_ADDR_BYTE | 8'h01)
                                : `TARGET_ADDR_BYTE;
                            d.state = cs_byte;
                        end
                    endcase
                end
                cs_byte: begin
                    case (q.qph)
                        // RULE_10: clock low two quarters only
                        2'h0: begin
                            d.scl = 1'b0;
                            d.sda_oe_n = (q.bitn == 4'h8) ? 1'b1 : q.sh[7];
                        end
                        2'h2: d.scl = 1'b1;
                        2'h3: begin
                            if (q.bitn != 4'h8) begin
                                d.sh = {q.sh[6:0], 1'b0};
                                d.bitn = q.bitn + 4'h1;
                            end else if (q.sda_s2) begin
                                // RULE_02: NACK aborts with STOP
                                d.nack_err = 1'b1;
                                d.state = cs_stop;
                            end else begin
                                d.bitn = 4'h0;
                                case (q.stage)
                                    sg_addr_w: begin
                                        // RULE_17: location follows address
                                        d.sh = q.loc;
                                        d.stage = sg_loc;
                                    end
                                    sg_loc: begin
                                        if (q.kind == ck_set_read) begin
                                            // RULE_07: repeated START for read
                                            d.stage = sg_addr_r;
                                            d.state = cs_start;
                                        end else if (q.left != 8'h00) begin
                                            // RULE_01: data after location
                                            d.sh = wdata;
                                            d.wdata_take = 1'b1;
                                            d.stage = sg_wdata;
                                        end else begin
                                            d.state = cs_stop;
                                        end
                                    end
                                    sg_wdata: begin
                                        d.left = q.left - 8'h01;
                                        if (q.left > 8'h01) begin
                                            // RULE_03: further bytes in order
                                            d.sh = wdata;
                                            d.wdata_take = 1'b1;
                                        end else begin
                                            d.state = cs_stop;
                                        end
                                    end
                                    default: begin
                                        d.stage = sg_rdata;
                                        d.state = cs_rbyte;
                                    end
                                endcase
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                cs_rbyte: begin
                    case (q.qph)
                        2'h0: begin
                            d.scl = 1'b0;
                            // RULE_08: ACK when more wanted
                            // RULE_09: NACK the last byte
                            d.sda_oe_n = (q.bitn != 4'h8) || (q.left <= 8'h01);
                        end
                        2'h2: d.scl = 1'b1;
                        2'h3: begin
                            if (q.bitn != 4'h8) begin
                                d.sh = {q.sh[6:0], q.sda_s2};
                                d.bitn = q.bitn + 4'h1;
                            end else begin
                                d.rdata = q.sh;
                                d.rdata_valid = 1'b1;
                                d.bitn = 4'h0;
                                d.left = q.left - 8'h01;
                                if (q.left <= 8'h01) begin
                                    d.state = cs_stop;
                                end
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                cs_stop: begin
                    case (q.qph)
                        2'h0: begin
                            d.scl = 1'b0;
                            d.sda_oe_n = 1'b0;
                        end
                        2'h2: d.scl = 1'b1;
                        2'h3: begin
                            d.sda_oe_n = 1'b1;
                            d.done = 1'b1;
                            d.ready = 1'b1;
                            d.state = cs_idle;
                        end
                        default: begin
                        end
                    endcase
                end
                default: d.state = cs_idle;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{
                sda_s1: 1'b1,
                sda_s2: 1'b1,
                state: cs_idle,
                stage: sg_addr_w,
                kind: ck_write,
                qph: 2'h0,
                div: '0,
                bitn: 4'h0,
                sh: 8'h00,
                loc: 8'h00,
                left: 8'h00,
                scl: 1'b1,
                sda_o: 1'b0,
                sda_oe_n: 1'b1,
                ready: 1'b1,
                wdata_take: 1'b0,
                rdata: 8'h00,
                rdata_valid: 1'b0,
                done: 1'b0,
                nack_err: 1'b0
            };
        end else begin
            q <= d;
        end
    end

    assign bus.scl = q.scl;
    assign bus.ctl_sda_o = q.sda_o;
    assign bus.ctl_sda_oe_n = q.sda_oe_n;
    assign cmd_ready = q.ready;
    assign wdata_take = q.wdata_take;
    assign rdata = q.rdata;
    assign rdata_valid = q.rdata_valid;
    assign done = q.done;
    assign nack_err = q.nack_err;

endmodule

`default_nettype wire

// ===== design/rtc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface rtc_link_if;
    logic scl;
    logic sda;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic ctl_sda_o;
    logic ctl_sda_oe_n;

    // Pulled-up wire: low when either side drives a zero
    assign sda = (dev_sda_oe_n | dev_sda_o) & (ctl_sda_oe_n | ctl_sda_o);

    modport device (
        input scl,
        input sda,
        output dev_sda_o,
        output dev_sda_oe_n
    );

    modport controller (
        output scl,
        input sda,
        output ctl_sda_o,
        output ctl_sda_oe_n
    );
endinterface

`default_nettype wire

// ===== design/rtc_port_pkg.sv
`include "rtc_port_regs.svh"

package rtc_port_pkg;

    typedef enum logic [2:0] {
        ds_idle,
        ds_rx,
        ds_ack,
        ds_tx,
        ds_mack
    } dev_state_t;

    typedef enum logic [1:0] {
        ph_addr,
        ph_loc,
        ph_data
    } dev_phase_t;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic osc_s1;
        logic osc_s2;
        dev_state_t state;
        dev_phase_t phase;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic rw;
        logic nack;
        logic [7:0] cnt;
        logic [`TMO_W-1:0] tmo;
        logic sda_o;
        logic sda_oe_n;
        logic wr_en;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } dev_regs_t;

    typedef enum logic [1:0] {
        ck_write,
        ck_set_read,
        ck_read
    } cmd_kind_t;

    typedef enum logic [2:0] {
        cs_idle,
        cs_start,
        cs_byte,
        cs_rbyte,
        cs_stop
    } ctl_state_t;

    typedef enum logic [2:0] {
        sg_addr_w,
        sg_loc,
        sg_wdata,
        sg_addr_r,
        sg_rdata
    } ctl_stage_t;

    typedef struct packed {
        logic sda_s1;
        logic sda_s2;
        ctl_state_t state;
        ctl_stage_t stage;
        cmd_kind_t kind;
        logic [1:0] qph;
        logic [`QDIV_W-1:0] div;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] loc;
        logic [7:0] left;
        logic scl;
        logic sda_o;
        logic sda_oe_n;
        logic ready;
        logic wdata_take;
        logic [7:0] rdata;
        logic rdata_valid;
        logic done;
        logic nack_err;
    } ctl_regs_t;

endpackage

// ===== design/rtc_port_regs.svh
`ifndef RTC_PORT_REGS_SVH
`define RTC_PORT_REGS_SVH

// Fixed target address byte, direction bit clear
`define TARGET_ADDR_BYTE 8'hD0
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1

// Core clock rate
`define CLK_MHZ 100

// Clock-low timeout window, microseconds
`define BUS_LOW_LIMIT_MIN_US 25000
`define BUS_LOW_RESET_TIME_MAX_US 35000
// Longest time scaled exactly to whole core cycles
`define BUS_LOW_RESET_CYCLES (`BUS_LOW_RESET_TIME_MAX_US * `CLK_MHZ)
`define TMO_W 24

// Controller serial clock: quarter period in core cycles (160 ns period)
`define SCL_PERIOD_NS 160
`define SCL_QUARTER_CYC ((`SCL_PERIOD_NS * `CLK_MHZ) / 4000)
`define QDIV_W 4

`endif

// ===== design/rtc_serial_target_port.sv
// What this block and rtc_bus_controller do
// RULE_01: Controller writes START, address, location, data, STOP.
// RULE_02: Every received write byte is acknowledged.
// RULE_03: Several write bytes go to successive locations.
// RULE_04: Reads start at the current address counter.
// RULE_05: Single read: START, address read, NACK, STOP.
// RULE_06: Location-only write just loads the counter.
// RULE_07: Dummy write then repeated START reads chosen location.
// RULE_08: ACKed read bytes are followed by further bytes.
// RULE_09: NACK on last read makes target release data.
// RULE_10: Controller keeps clock low shorter than limit.
// RULE_11: Clock held low long resets the interface.
// RULE_12: On timeout the data line is released.
// RULE_13: Timeout only while oscillator runs.
// RULE_14: Target never holds the clock low.
// RULE_15: Target only pulls data low or releases.
// RULE_16: Only the fixed address is answered; else ignore.
// RULE_17: First byte after write address is the location.
// RULE_18: Bits sampled on rising clock, MSB first.
// RULE_19: Output bits change on falling clock edge.
// RULE_20: Counter advances after each data byte.
`timescale 1ns/1ps
`default_nettype none

module rtc_serial_target_port
    import rtc_port_pkg::*;
#(
    parameter logic [`TMO_W-1:0] BUS_LOW_RESET_CYCLES = `TMO_W'(`BUS_LOW_RESET_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Serial link
    rtc_link_if.device bus,
    // Timekeeping oscillator status
    input wire logic osc_running,
    // Memory space
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data
);

    dev_regs_t q;
    dev_regs_t d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic timed_out;

    // RULE_18: rising edge sample
    assign scl_rise = q.scl_s2 & ~q.scl_s3;
    // RULE_19: falling edge drive
    assign scl_fall = ~q.scl_s2 & q.scl_s3;
    assign start_seen = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    assign stop_seen = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
    assign timed_out = (q.tmo == BUS_LOW_RESET_CYCLES);

    always_comb begin
        d = q;
        d.wr_en = 1'b0;
        // RULE_14: clock only sampled
        d.scl_s1 = bus.scl;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = bus.sda;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;
        d.osc_s1 = osc_running;
        d.osc_s2 = q.osc_s1;
        // RULE_15: output level fixed low
        d.sda_o = 1'b0;
        // RULE_13: count only with oscillator
        if (q.osc_s2 && !q.scl_s2) begin
            if (!timed_out) begin
                d.tmo = q.tmo + `TMO_W'(1);
            end
        end else begin
            d.tmo = '0;
        end
        if (timed_out) begin
            // RULE_11: interface back to idle
            d.state = ds_idle;
            // RULE_12: release data line
            d.sda_oe_n = 1'b1;
        end else if (start_seen) begin
            d.state = ds_rx;
            d.phase = ph_addr;
            d.bitn = 4'h0;
            d.sda_oe_n = 1'b1;
        end else if (stop_seen) begin
            d.state = ds_idle;
            d.sda_oe_n = 1'b1;
        end else begin
            case (q.state)
                ds_rx: begin
                    if (scl_rise) begin
                        // RULE_18: shift in MSB first
                        d.sh = {q.sh[6:0], q.sda_s2};
                        d.bitn = q.bitn + 4'h1;
                    end else if (scl_fall && q.bitn == 4'h8) begin
                        // RULE_02: acknowledge the byte
                        d.state = ds_ack;
                        d.sda_oe_n = 1'b0;
                        case (q.phase)
                            ph_addr: begin
                                // RULE_16: fixed address match
                                if (q.sh[7:1] == 7'(`TARGET_ADDR_BYTE >> 1)) begin
                                    d.rw = q.sh[0];
                                    // RULE_17: next byte is location
                                    d.phase = ph_loc;
                                end else begin
                                    d.state = ds_idle;
                                    d.sda_oe_n = 1'b1;
                                end
                            end
                            ph_loc: begin
                                // RULE_06: location loads counter
                                d.cnt = q.sh;
                                d.phase = ph_data;
                            end
                            default: begin
                                // RULE_03: store at counter
                                d.wr_en = 1'b1;
                                d.wr_addr = q.cnt;
                                d.wr_data = q.sh;
                                // RULE_20: advance counter
                                d.cnt = q.cnt + 8'h01;
                            end
                        endcase
                    end
                end
                ds_ack: begin
                    if (scl_fall) begin
                        d.bitn = 4'h0;
                        if (q.rw == `DIR_READ) begin
                            // RULE_04: read at current counter
                            d.sh = rd_data;
                            d.sda_oe_n = rd_data[7];
                            d.state = ds_tx;
                        end else begin
                            d.sda_oe_n = 1'b1;
                            d.state = ds_rx;
                        end
                    end
                end
                ds_tx: begin
                    if (scl_rise) begin
                        d.bitn = q.bitn + 4'h1;
                    end else if (scl_fall) begin
                        if (q.bitn == 4'h8) begin
                            d.sda_oe_n = 1'b1;
                            d.state = ds_mack;
                            // RULE_20: advance after read byte
                            d.cnt = q.cnt + 8'h01;
                        end else begin
                            // RULE_19: next bit on falling edge
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_oe_n = q.sh[6];
                        end
                    end
                end
                ds_mack: begin
                    if (scl_rise) begin
                        d.nack = q.sda_s2;
                    end else if (scl_fall) begin
                        d.bitn = 4'h0;
                        if (!q.nack) begin
                            // RULE_08: keep sending next location
                            d.sh = rd_data;
                            d.sda_oe_n = rd_data[7];
                            d.state = ds_tx;
                        end else begin
                            // RULE_09: release after NACK
                            d.sda_oe_n = 1'b1;
                            d.state = ds_idle;
                        end
                    end
                end
                default: begin
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{
                scl_s1: 1'b1,
                scl_s2: 1'b1,
                scl_s3: 1'b1,
                sda_s1: 1'b1,
                sda_s2: 1'b1,
                sda_s3: 1'b1,
                osc_s1: 1'b0,
                osc_s2: 1'b0,
                state: ds_idle,
                phase: ph_addr,
                bitn: 4'h0,
                sh: 8'h00,
                rw: 1'b0,
                nack: 1'b1,
                cnt: 8'h00,
                tmo: '0,
                sda_o: 1'b0,
                sda_oe_n: 1'b1,
                wr_en: 1'b0,
                wr_addr: 8'h00,
                wr_data: 8'h00
            };
        end else begin
            q <= d;
        end
    end

    assign bus.dev_sda_o = q.sda_o;
    assign bus.dev_sda_oe_n = q.sda_oe_n;
    assign rd_addr = q.cnt;
    assign wr_en = q.wr_en;
    assign wr_addr = q.wr_addr;
    assign wr_data = q.wr_data;

endmodule

`default_nettype wire

// ===== tb/rtc_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_link_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Link signals
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic ctl_sda_o,
    input wire logic ctl_sda_oe_n
);
    logic scl_q, sda_q, rw_q, nak_q;
    logic [3:0] bit_q;
    logic [7:0] byte_q;
    wire rise = scl && !scl_q;
    wire sta = scl && scl_q && sda_q && !sda;
    wire ackb = rise && bit_q == 4'h8;
    wire rdb = rw_q && byte_q != 8'h00;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Frame tracker: clock pulses and bytes since START
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rw_q <= 1'b0;
            nak_q <= 1'b0;
            bit_q <= 4'h0;
            byte_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (sta) begin
                bit_q <= 4'h0;
                byte_q <= 8'h00;
                nak_q <= 1'b0;
            end else if (rise) begin
                bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
                if (bit_q == 4'h8)
                    byte_q <= byte_q + 8'h01;
                if (byte_q == 8'h00 && bit_q == 4'h7)
                    rw_q <= sda;
                if (ackb && sda)
                    nak_q <= 1'b1;
            end
        end
    end

    property p_open_drain;
        dev_sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("device drives data line high");
    property p_edge;
        $changed(dev_sda_oe_n) |-> !scl;
    endproperty
    a_edge: assert property (p_edge)
        else $error("device data changed while clock high");
    property p_ack;
        ackb && (byte_q == 8'h00 || !rw_q) |-> !dev_sda_oe_n [*8];
    endproperty
    a_ack: assert property (p_ack)
        else $error("received byte not acknowledged");
    property p_ctl_rel;
        ackb && !rdb |-> ctl_sda_oe_n;
    endproperty
    a_ctl_rel: assert property (p_ctl_rel)
        else $error("controller drives during device acknowledge");
    property p_quiet;
        rise && byte_q == 8'h00 && bit_q < 4'h8 |-> dev_sda_oe_n;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("device drives during address bits");
    property p_rd_rel;
        rise && rdb && !nak_q && bit_q < 4'h8 |-> ctl_sda_oe_n;
    endproperty
    a_rd_rel: assert property (p_rd_rel)
        else $error("controller drives during read data bits");
    property p_nack;
        ackb && rdb && sda |=> dev_sda_oe_n [*8];
    endproperty
    a_nack: assert property (p_nack)
        else $error("device drives after final read byte");
    property p_scl_low;
        $fell(scl) |-> ##[1:16] scl;
    endproperty
    a_scl_low: assert property (p_scl_low)
        else $error("serial clock held low too long");

    c_wr: cover property (ackb && !rw_q && byte_q == 8'h02);
    c_nack: cover property (ackb && rdb && sda);
    c_rs: cover property (sta && byte_q != 8'h00);
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rtc_port_pkg::*;
    logic clk, nrst, cmd_valid, cmd_ready, wdata_take, rdata_valid, done, nack_err;
    logic wr_en, osc2, ak, bs, bd;
    cmd_kind_t cmd_kind;
    logic [7:0] cmd_loc, cmd_len, rd_addr, wr_addr, wr_data, rdata;
    logic [7:0] mem [256];
    logic [7:0] wq [5];
    logic [7:0] rq [8];
    int wi, ri, fail_count, checked;

    rtc_link_if i_rtc_link_if ();
    rtc_link_if i_rtc_link_if_b ();
    assign i_rtc_link_if_b.scl = bs;
    assign i_rtc_link_if_b.ctl_sda_o = 1'b0;
    assign i_rtc_link_if_b.ctl_sda_oe_n = bd;

    rtc_serial_target_port #(.BUS_LOW_RESET_CYCLES(24'h0000C8)) i_rtc_serial_target_port (
        .clk(clk), .nrst(nrst), .bus(i_rtc_link_if), .osc_running(1'b1), .rd_addr(rd_addr),
        .rd_data(mem[rd_addr]), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    rtc_bus_controller i_rtc_bus_controller (.clk(clk), .nrst(nrst), .bus(i_rtc_link_if),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_loc(cmd_loc), .cmd_len(cmd_len),
        .cmd_ready(cmd_ready), .wdata(wq[wi]), .wdata_take(wdata_take), .rdata(rdata),
        .rdata_valid(rdata_valid), .done(done), .nack_err(nack_err));
    rtc_serial_target_port #(.BUS_LOW_RESET_CYCLES(24'h0000C8)) i_rtc_serial_target_port_b (
        .clk(clk), .nrst(nrst), .bus(i_rtc_link_if_b), .osc_running(osc2), .rd_addr(),
        .rd_data(8'h00), .wr_en(), .wr_addr(), .wr_data());
    rtc_link_asserts u_chk (.clk(clk), .nrst(nrst), .scl(i_rtc_link_if.scl),
        .sda(i_rtc_link_if.sda), .dev_sda_o(i_rtc_link_if.dev_sda_o),
        .dev_sda_oe_n(i_rtc_link_if.dev_sda_oe_n), .ctl_sda_o(i_rtc_link_if.ctl_sda_o),
        .ctl_sda_oe_n(i_rtc_link_if.ctl_sda_oe_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Memory space, write data feed and read capture
    always @(posedge clk) begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        if (wdata_take)
            wi <= wi + 1;
        if (rdata_valid)
            rq[ri] <= rdata;
        if (rdata_valid)
            ri <= ri + 1;
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmd(input cmd_kind_t k, input logic [7:0] l, input logic [7:0] n);
        int t;
        cmd_valid = 1'b1;
        cmd_kind = k;
        cmd_loc = l;
        cmd_len = n;
        while (cmd_ready !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        t = 0;
        while (done !== 1'b1 && t < 4000) begin
            @(negedge clk);
            t++;
        end
        cmp({7'h00, done}, 8'h01);
        cmp({7'h00, nack_err}, 8'h00);
    endtask

    // Bit-banged controller on the second link, 160 ns clock period
    task automatic ph(input logic s, input logic d);
        bs = s;
        bd = d;
        repeat (8) @(negedge clk);
    endtask

    task automatic bit1(input logic d, output logic s);
        ph(1'b0, d);
        ph(1'b1, d);
        s = i_rtc_link_if_b.sda;
    endtask

    task automatic frame(input logic [7:0] b, input logic st, output logic a);
        logic x;
        if (st) begin
            ph(1'b1, 1'b1);
            ph(1'b1, 1'b0);
            ph(1'b0, 1'b0);
        end
        for (int i = 7; i >= 0; i--)
            bit1(b[i], x);
        bit1(1'b1, a);
    endtask

    initial begin
        nrst = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = ck_write;
        cmd_loc = 8'h00;
        cmd_len = 8'h00;
        bs = 1'b1;
        bd = 1'b1;
        osc2 = 1'b0;
        wi = 0;
        ri = 0;
        fail_count = 0;
        checked = 0;
        wq = '{8'hA1, 8'hB2, 8'hC3, 8'h11, 8'h22};
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'h5A;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        cmd(ck_write, 8'h10, 8'h03);
        cmd(ck_set_read, 8'h10, 8'h03);
        for (int i = 0; i < 3; i++) begin
            cmp(mem[8'h10 + i], wq[i]);
            cmp(rq[i], wq[i]);
        end
        cmp(rd_addr, 8'h13);
        cmd(ck_write, 8'h40, 8'h00);
        cmp(rd_addr, 8'h40);
        cmp(mem[8'h40], 8'h1A);
        cmd(ck_read, 8'h77, 8'h01);
        cmp(rq[3], 8'h1A);
        cmp(rd_addr, 8'h41);
        cmd(ck_write, 8'hFF, 8'h02);
        cmp(mem[8'hFF], 8'h11);
        cmp(mem[8'h00], 8'h22);
        // Foreign address is ignored until a fresh START
        frame(8'hA0, 1'b1, ak);
        cmp({7'h00, ak}, 8'h01);
        frame(8'hD0, 1'b0, ak);
        cmp({7'h00, ak}, 8'h01);
        frame(8'hD1, 1'b1, ak);
        cmp({7'h00, ak}, 8'h00);
        // Clock held low while the device drives a zero bit
        ph(1'b0, 1'b1);
        repeat (400) @(negedge clk);
        cmp({7'h00, i_rtc_link_if_b.sda}, 8'h00);
        osc2 = 1'b1;
        repeat (400) @(negedge clk);
        cmp({7'h00, i_rtc_link_if_b.sda}, 8'h01);
        frame(8'hD0, 1'b1, ak);
        cmp({7'h00, ak}, 8'h00);
        test_done;
    end

    initial begin
        #200000;
        fail_count++;
        test_done;
    end
endmodule

`default_nettype wire
